/* rtl/eai_defs.svh */
`ifndef EAI_DEFS_SVH
`define EAI_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define EAI_NUM_EV      6'h22
`define EAI_EV_W        6
`define EAI_HND_W       7
`define EAI_CTX_W       64
`define EAI_QMAX        16
`define EAI_QP_W        4
`define EAI_QC_W        5
`define EAI_QD_COMM     5'h04
`define EAI_QD_IO       5'h10
`define EAI_QD_TIMED    5'h08

// ****************************************
// Queue classes
// ****************************************
`define EAI_CLS_COMM    2'h0
`define EAI_CLS_IO      2'h1
`define EAI_CLS_TIMED   2'h2
`define EAI_NUM_CLS     3

// ****************************************
// Event numbers
// ****************************************
`define EAI_EV_EDGE_LAST 6'h07
`define EAI_EV_P0_RX     6'h08
`define EAI_EV_P0_TX     6'h09
`define EAI_EV_TIMED0    6'h0A
`define EAI_EV_TIMED1    6'h0B
`define EAI_EV_FC0_EQ    6'h0C
`define EAI_EV_FC1_EQ    6'h0D
`define EAI_EV_FC2_EQ    6'h10
`define EAI_EV_PULSE0    6'h13
`define EAI_EV_PULSE1    6'h14
`define EAI_EV_TMR_A     6'h15
`define EAI_EV_TMR_B     6'h16
`define EAI_EV_P0_MSG    6'h17
`define EAI_EV_P1_MSG    6'h18
`define EAI_EV_P1_RX     6'h19
`define EAI_EV_P1_TX     6'h1A
`define EAI_EV_FC4_EQ    6'h1D
`define EAI_EV_FC3_EQ    6'h20
`define EAI_EV_FC5_EQ    6'h21

`endif

/* rtl/eai_pkg.sv */
package eai_pkg;
    typedef enum logic [2:0] {
        OP_BIND,
        OP_UNBIND,
        OP_GATE_OPEN,
        OP_GATE_CLOSE,
        OP_COND_EXIT,
        OP_HANDLER_END,
        OP_COUNTER_DEFINE,
        OP_PROGRAM_END
    } eai_op_t;

    typedef enum logic {
        ST_MAIN,
        ST_HANDLER
    } eai_state_t;
endpackage

/* rtl/eai_unit.sv */
`timescale 1ns/1ps
`include "eai_defs.svh"
// Functional notes
// - Many events may share one handler; each event holds one binding only.
// - Bind stores the handler number and enables the event in one step.
// - Enabled events are queued while the gate is closed, until reopen or overflow.
// - Unbind removes the binding and disables the event; later occurrences ignored.
// - Serial events fixed: port 0 is 8, 9, 23; port 1 is 24 to 26.
// - Counter equal events fixed: 12, 13, 16, 29, 32, 33.
// - Pulse output zero completion is event 19, pulse output one is 20.
// - After the handler's last instruction, control returns to the main program.
// - Conditional exit ends the handler early when its condition is true.
// - Context is saved at dispatch and restored on return.
// - Moves are single instructions; dispatch only happens at instruction boundaries.
// - With the gate closed nothing is dispatched; pending events wait for reopen.
// - On entry to run the gate is closed until the open op.
// - A running handler is never pre-empted; new events are queued.
// - Per-queue lost flag set on overflow, cleared when empty on return.
module eai_unit (
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    input  wire logic                    ce_in,
    input  wire logic                    run_entry_in,
    input  wire logic                    ev_valid_in,
    input  wire logic [`EAI_EV_W-1:0]    ev_num_in,
    input  wire logic                    op_valid_in,
    input  wire eai_pkg::eai_op_t        op_code_in,
    input  wire logic [`EAI_EV_W-1:0]    op_event_in,
    input  wire logic [`EAI_HND_W-1:0]   op_handler_in,
    input  wire logic                    op_cond_in,
    input  wire logic                    instr_boundary_in,
    input  wire logic [`EAI_CTX_W-1:0]   ctx_in,
    output logic                         dispatch_out,
    output logic [`EAI_HND_W-1:0]        handler_num_out,
    output logic                         in_handler_out,
    output logic                         resume_out,
    output logic [`EAI_CTX_W-1:0]        ctx_out,
    output logic                         gate_open_out,
    output logic [`EAI_NUM_CLS-1:0]      lost_out,
    output logic                         op_error_out
);

    // ****************************************
    // Functions
    // ****************************************
    // event classes
    function automatic logic [1:0] cls_of(input logic [`EAI_EV_W-1:0] ev);
        logic [1:0] c;
        c = `EAI_CLS_IO;
        case (ev)
            `EAI_EV_P0_RX, `EAI_EV_P0_TX, `EAI_EV_P0_MSG,
            `EAI_EV_P1_MSG, `EAI_EV_P1_RX, `EAI_EV_P1_TX: c = `EAI_CLS_COMM;
            `EAI_EV_TIMED0, `EAI_EV_TIMED1,
            `EAI_EV_TMR_A, `EAI_EV_TMR_B: c = `EAI_CLS_TIMED;
            `EAI_EV_FC0_EQ, `EAI_EV_FC1_EQ, `EAI_EV_FC2_EQ, `EAI_EV_FC3_EQ,
            `EAI_EV_FC4_EQ, `EAI_EV_FC5_EQ,
            `EAI_EV_PULSE0, `EAI_EV_PULSE1: c = `EAI_CLS_IO;
            default: c = `EAI_CLS_IO;
        endcase
        return c;
    endfunction

    function automatic logic [`EAI_QC_W-1:0] qdepth(input int c);
        logic [`EAI_QC_W-1:0] d;
        d = `EAI_QD_IO;
        if (c == int'(`EAI_CLS_COMM)) begin
            d = `EAI_QD_COMM;
        end else if (c == int'(`EAI_CLS_TIMED)) begin
            d = `EAI_QD_TIMED;
        end
        return d;
    endfunction

    function automatic logic [`EAI_QP_W-1:0] ptr_inc(input logic [`EAI_QP_W-1:0] p,
                                                     input int c);
        logic [`EAI_QP_W-1:0] n;
        n = p + 4'h1;
        if ({1'b0, p} == qdepth(c) - 5'h01) begin
            n = 4'h0;
        end
        return n;
    endfunction

    // ****************************************
    // State
    // ****************************************
    eai_pkg::eai_state_t     state_reg;
    logic [`EAI_HND_W-1:0]   hnd_tab [`EAI_NUM_EV];
    logic [`EAI_NUM_EV-1:0]  en_reg;
    logic [`EAI_EV_W-1:0]    q_mem [`EAI_NUM_CLS][`EAI_QMAX];
    logic [`EAI_QP_W-1:0]    q_wr [`EAI_NUM_CLS];
    logic [`EAI_QP_W-1:0]    q_rd [`EAI_NUM_CLS];
    logic [`EAI_QC_W-1:0]    q_cnt [`EAI_NUM_CLS];
    logic [`EAI_CTX_W-1:0]   ctx_save_reg;

    // ****************************************
    // Decoding
    // ****************************************
    wire        in_hnd   = (state_reg == eai_pkg::ST_HANDLER);
    wire [1:0]  ev_cls   = cls_of(ev_num_in);
    wire        ev_legal = ev_valid_in && (ev_num_in < `EAI_NUM_EV);
    // Disabled events are ignored unbind effect
    wire        ev_take  = ev_legal && en_reg[ev_num_in];
    wire        op_ok    = op_valid_in && (op_event_in < `EAI_NUM_EV);
    wire        is_bind  = op_ok && (op_code_in == eai_pkg::OP_BIND);
    wire        is_unb   = op_ok && (op_code_in == eai_pkg::OP_UNBIND);
    wire        is_open  = op_valid_in && (op_code_in == eai_pkg::OP_GATE_OPEN);
    wire        is_close = op_valid_in && (op_code_in == eai_pkg::OP_GATE_CLOSE);
    wire        is_bad   = op_valid_in && (is_open || is_close
                           || op_code_in == eai_pkg::OP_COUNTER_DEFINE
                           || op_code_in == eai_pkg::OP_PROGRAM_END);
    wire        op_bad   = in_hnd && is_bad;
    wire        end_now  = in_hnd && op_valid_in
                           && ((op_code_in == eai_pkg::OP_HANDLER_END)
                           || (op_code_in == eai_pkg::OP_COND_EXIT && op_cond_in));
    wire        pend_any = (q_cnt[0] != 5'h00) || (q_cnt[1] != 5'h00)
                           || (q_cnt[2] != 5'h00);
    // dispatch only at boundary, gate open, no handler
    wire        can_disp = !in_hnd && gate_open_out && instr_boundary_in
                           && pend_any && !run_entry_in;
    wire [1:0]  sel      = (q_cnt[0] != 5'h00) ? `EAI_CLS_COMM :
                           (q_cnt[1] != 5'h00) ? `EAI_CLS_IO : `EAI_CLS_TIMED;
    wire [`EAI_EV_W-1:0] head = q_mem[sel][q_rd[sel]];
    wire        head_en  = en_reg[head];

    logic [`EAI_NUM_CLS-1:0] push;
    logic [`EAI_NUM_CLS-1:0] pop;
    logic [`EAI_NUM_CLS-1:0] full;
    logic [`EAI_NUM_CLS-1:0] drop;
    always_comb begin
        for (int c = 0; c < `EAI_NUM_CLS; c++) begin
            pop[c]  = can_disp && (sel == c[1:0]);
            full[c] = (q_cnt[c] == qdepth(c));
            // queue regardless of gate; drop when full and not popped in the same cycle
            push[c] = ev_take && (ev_cls == c[1:0]) && (!full[c] || pop[c]);
            drop[c] = ev_take && (ev_cls == c[1:0]) && full[c] && !pop[c];
        end
    end

    // ****************************************
    // Binding table
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            en_reg <= '0;
        end else if (ce_in) begin
            if (is_bind) begin
                en_reg[op_event_in] <= 1'b1;
            end else if (is_unb) begin
                en_reg[op_event_in] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && is_bind) begin
            hnd_tab[op_event_in] <= op_handler_in;
        end
    end

    // ****************************************
    // Queues
    // ****************************************
    always_ff @(posedge clk_in) begin
        for (int c = 0; c < `EAI_NUM_CLS; c++) begin
            if (!rstn_in) begin
                q_wr[c]     <= 4'h0;
                q_rd[c]     <= 4'h0;
                q_cnt[c]    <= 5'h00;
                lost_out[c] <= 1'b0;
            end else if (ce_in) begin
                if (push[c]) begin
                    q_mem[c][q_wr[c]] <= ev_num_in;
                    q_wr[c]           <= ptr_inc(q_wr[c], c);
                end
                if (pop[c]) begin
                    q_rd[c] <= ptr_inc(q_rd[c], c);
                end
                q_cnt[c] <= q_cnt[c] + {4'h0, push[c]} - {4'h0, pop[c]};
                // lost flag, set wins over clear
                if (drop[c]) begin
                    lost_out[c] <= 1'b1;
                end else if (end_now && q_cnt[c] == 5'h00 && !push[c]) begin
                    lost_out[c] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Dispatch and return
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_reg       <= eai_pkg::ST_MAIN;
            gate_open_out   <= 1'b0;
            dispatch_out    <= 1'b0;
            resume_out      <= 1'b0;
            in_handler_out  <= 1'b0;
            op_error_out    <= 1'b0;
            handler_num_out <= 7'h00;
            ctx_out         <= 64'h0000_0000_0000_0000;
            ctx_save_reg    <= 64'h0000_0000_0000_0000;
        end else if (ce_in) begin
            dispatch_out <= 1'b0;
            resume_out   <= 1'b0;
            op_error_out <= op_bad;
            if (run_entry_in) begin
                gate_open_out <= 1'b0;
            end else if (!in_hnd && is_open) begin
                gate_open_out <= 1'b1;
            end else if (!in_hnd && is_close) begin
                gate_open_out <= 1'b0;
            end
            case (state_reg)
                eai_pkg::ST_MAIN: begin
                    if (can_disp && head_en) begin
                        ctx_save_reg    <= ctx_in;
                        handler_num_out <= hnd_tab[head];
                        dispatch_out    <= 1'b1;
                        in_handler_out  <= 1'b1;
                        state_reg       <= eai_pkg::ST_HANDLER;
                    end
                end
                eai_pkg::ST_HANDLER: begin
                    if (end_now) begin
                        ctx_out        <= ctx_save_reg;
                        resume_out     <= 1'b1;
                        in_handler_out <= 1'b0;
                        state_reg      <= eai_pkg::ST_MAIN;
                    end
                end
                default: begin
                    state_reg <= eai_pkg::ST_MAIN;
                end
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    wire [`EAI_QC_W-1:0] cls_cnt = q_cnt[ev_cls];
    sequence s_end_req;
        ce_in && end_now;
    endsequence
    sequence s_resumed;
        resume_out && !in_handler_out;
    endsequence

    gate_after_run_a: assert property (ce_in && run_entry_in |=> !gate_open_out)
        else $error("gate open after run entry");
    bind_enables_a: assert property (ce_in && is_bind |=> en_reg[$past(op_event_in)]
        && hnd_tab[$past(op_event_in)] == $past(op_handler_in))
        else $error("bind did not enable");
    unbind_clears_a: assert property (ce_in && is_unb |=> !en_reg[$past(op_event_in)])
        else $error("unbind left event enabled");
    closed_no_disp_a: assert property (ce_in && !gate_open_out |=> !dispatch_out)
        else $error("dispatch with gate closed");
    no_preempt_a: assert property (ce_in && in_handler_out |=> !dispatch_out)
        else $error("handler pre-empted");
    boundary_disp_a: assert property ($past(ce_in) && dispatch_out
        |-> $past(instr_boundary_in))
        else $error("dispatch off boundary");
    handler_return_a: assert property (s_end_req |=> s_resumed ##1 !resume_out)
        else $error("no return after handler end");
    cond_false_a: assert property (ce_in && in_hnd && op_valid_in && !op_cond_in
        && op_code_in == eai_pkg::OP_COND_EXIT |=> in_handler_out && !resume_out)
        else $error("exit taken on false condition");
    ctx_restore_a: assert property ($rose(resume_out) |-> ctx_out == ctx_save_reg
        && $past(in_handler_out))
        else $error("context not restored");
    bad_op_a: assert property (ce_in && op_bad |=> op_error_out && $stable(gate_open_out))
        else $error("forbidden op not rejected");
    lost_set_a: assert property (ce_in && (|drop) |=> lost_out[$past(ev_cls)])
        else $error("lost flag not set");
    full_keep_a: assert property (ce_in && (|drop) && !(|pop)
        |=> q_cnt[$past(ev_cls)] == $past(cls_cnt))
        else $error("full queue changed on drop");
    queued_closed_a: assert property (ce_in && !gate_open_out && (|push) && !(|pop)
        |=> q_cnt[$past(ev_cls)] == $past(cls_cnt) + 5'h01)
        else $error("occurrence not queued");

endmodule

/* tb/eai_core_model.sv */
`timescale 1ns/1ps
`include "eai_defs.svh"
// ****************************************
// Processor core model
// ****************************************
module eai_core_model (
    input  wire logic                  clk_in,
    input  wire logic                  move_in,
    input  wire logic                  in_handler_in,
    output logic                       boundary_out,
    output logic [`EAI_CTX_W-1:0]      ctx_out
);
    logic [`EAI_CTX_W-1:0] ctx_reg = 64'h0123_4567_89AB_CDEF;
    assign boundary_out = !move_in;
    always_ff @(posedge clk_in) begin
        if (in_handler_in === 1'b0) begin
            ctx_reg <= ctx_reg + 64'h0000_0000_0000_0001;
        end
    end
    assign ctx_out = (in_handler_in === 1'b1) ? ~ctx_reg : ctx_reg;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "eai_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
    logic clk_in = 0, rstn_in = 0, run_entry_in = 0, ev_valid_in = 0, op_valid_in = 0;
    logic op_cond_in = 0, move = 0, ce = 1, bnd, dispatch_out, in_handler_out, resume_out;
    logic gate_open_out, op_error_out;
    logic [5:0] ev_num_in = 0, op_event_in = 0;
    logic [6:0] op_handler_in = 0, handler_num_out;
    logic [63:0] ctx, ctx_out, exp_ctx;
    logic [2:0] lost_out;
    eai_pkg::eai_op_t op_code_in = eai_pkg::OP_BIND;
    int bad_count = 0, num_checks = 0, n_disp = 0, n_err = 0;
    eai_unit dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .run_entry_in(run_entry_in), .ev_valid_in(ev_valid_in), .ev_num_in(ev_num_in),
        .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_event_in(op_event_in),
        .op_handler_in(op_handler_in), .op_cond_in(op_cond_in), .instr_boundary_in(bnd),
        .ctx_in(ctx), .dispatch_out(dispatch_out), .handler_num_out(handler_num_out),
        .in_handler_out(in_handler_out), .resume_out(resume_out), .ctx_out(ctx_out),
        .gate_open_out(gate_open_out), .lost_out(lost_out), .op_error_out(op_error_out));
    eai_core_model core (.clk_in(clk_in), .move_in(move), .in_handler_in(in_handler_out),
        .boundary_out(bnd), .ctx_out(ctx));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // ****************************************
    // Pulse monitor
    // ****************************************
    always @(negedge clk_in) begin
        if (dispatch_out === 1'b1) begin
            n_disp++;
            exp_ctx = ~ctx - 64'h0000_0000_0000_0001;
        end
        if (op_error_out === 1'b1) n_err++;
    end
    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic op(input eai_pkg::eai_op_t c, input logic [5:0] e, input logic [6:0] h,
                      input logic cnd);
        @(negedge clk_in);
        op_valid_in = 1;
        op_code_in = c;
        op_event_in = e;
        op_handler_in = h;
        op_cond_in = cnd;
        @(negedge clk_in);
        op_valid_in = 0;
    endtask
    task automatic ev(input logic [5:0] e);
        @(negedge clk_in);
        ev_valid_in = 1;
        ev_num_in = e;
        @(negedge clk_in);
        ev_valid_in = 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wait_disp(input logic [6:0] h);
        int n0;
        n0 = n_disp;
        for (int i = 0; i < 30 && n_disp == n0; i++) @(posedge clk_in);
        `CHK("dispatch", 1, n_disp - n0);
        `CHK("handler", h, handler_num_out);
        `CHK("in_handler", 1'b1, in_handler_out);
    endtask
    task automatic end_h();
        op(eai_pkg::OP_HANDLER_END, 0, 0, 0);
        `CHK("resume", 1'b1, resume_out);
        `CHK("ctx", exp_ctx, ctx_out);
        `CHK("in_handler", 1'b0, in_handler_out);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_run_entry();
        op(eai_pkg::OP_GATE_OPEN, 0, 0, 0);
        `CHK("gate opened", 1'b1, gate_open_out);
        @(negedge clk_in);
        run_entry_in = 1;
        @(negedge clk_in);
        run_entry_in = 0;
        `CHK("gate", 1'b0, gate_open_out);
        `CHK("lost", 3'h0, lost_out);
        $display("test run_entry done");
    endtask
    task automatic t_dispatch();
        op(eai_pkg::OP_BIND, `EAI_EV_P0_RX, 7'h01, 0);
        op(eai_pkg::OP_GATE_OPEN, 0, 0, 0);
        `CHK("gate", 1'b1, gate_open_out);
        ev(`EAI_EV_P0_RX);
        wait_disp(7'h01);
        end_h();
        op(eai_pkg::OP_BIND, `EAI_EV_PULSE0, 7'h05, 0);
        op(eai_pkg::OP_BIND, `EAI_EV_FC0_EQ, 7'h05, 0);
        ev(`EAI_EV_PULSE0);
        wait_disp(7'h05);
        end_h();
        ev(`EAI_EV_FC0_EQ);
        wait_disp(7'h05);
        end_h();
        $display("test dispatch done");
    endtask
    task automatic t_gate_closed();
        int n0;
        n0 = n_disp;
        op(eai_pkg::OP_GATE_CLOSE, 0, 0, 0);
        ev(`EAI_EV_P0_RX);
        idle(10);
        `CHK("no dispatch", 0, n_disp - n0);
        op(eai_pkg::OP_GATE_OPEN, 0, 0, 0);
        wait_disp(7'h01);
        end_h();
        $display("test gate_closed done");
    endtask
    task automatic t_unbind();
        int n0;
        op(eai_pkg::OP_UNBIND, `EAI_EV_PULSE0, 0, 0);
        n0 = n_disp;
        ev(`EAI_EV_PULSE0);
        idle(10);
        `CHK("unbound", 0, n_disp - n0);
        $display("test unbind done");
    endtask
    task automatic t_handler_ops();
        int n0, e0;
        op(eai_pkg::OP_BIND, 6'h02, 7'h03, 0);
        op(eai_pkg::OP_BIND, 6'h03, 7'h04, 0);
        n0 = n_disp;
        move = 1;
        ev(6'h02);
        idle(8);
        `CHK("move", 0, n_disp - n0);
        @(negedge clk_in);
        move = 0;
        wait_disp(7'h03);
        n0 = n_disp;
        e0 = n_err;
        ev(6'h03);
        op(eai_pkg::OP_GATE_CLOSE, 0, 0, 0);
        op(eai_pkg::OP_COUNTER_DEFINE, 0, 0, 0);
        op(eai_pkg::OP_PROGRAM_END, 0, 0, 0);
        op(eai_pkg::OP_COND_EXIT, 0, 0, 0);
        idle(4);
        `CHK("op error", 3, n_err - e0);
        `CHK("gate kept", 1'b1, gate_open_out);
        `CHK("no preempt", 0, n_disp - n0);
        `CHK("cond false", 1'b1, in_handler_out);
        op(eai_pkg::OP_COND_EXIT, 0, 0, 1);
        `CHK("cond exit", 1'b0, in_handler_out);
        `CHK("cond ctx", exp_ctx, ctx_out);
        wait_disp(7'h04);
        end_h();
        $display("test handler_ops done");
    endtask
    task automatic t_overflow();
        op(eai_pkg::OP_GATE_CLOSE, 0, 0, 0);
        repeat (5) ev(`EAI_EV_P0_RX);
        idle(2);
        `CHK("lost set", 3'h1, lost_out);
        op(eai_pkg::OP_GATE_OPEN, 0, 0, 0);
        repeat (4) begin
            wait_disp(7'h01);
            end_h();
        end
        idle(10);
        `CHK("dropped", 1'b0, in_handler_out);
        `CHK("lost clear", 3'h0, lost_out);
        $display("test overflow done");
    endtask
    task automatic t_freeze();
        int n0;
        n0 = n_disp;
        @(negedge clk_in);
        ce = 0;
        op(eai_pkg::OP_BIND, `EAI_EV_P0_TX, 7'h02, 0);
        @(negedge clk_in);
        ce = 1;
        ev(`EAI_EV_P0_TX);
        idle(10);
        `CHK("frozen bind", 0, n_disp - n0);
        $display("test freeze done");
    endtask
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(negedge clk_in);
        rstn_in = 1;
        t_run_entry();
        t_dispatch();
        t_gate_closed();
        t_unbind();
        t_handler_ops();
        t_overflow();
        t_freeze();
        end_sim();
    end
endmodule
